/* zwsb_bus_seq.sv */
// zero-wait sram bus sequencer: local and global buses, two strobe sets each
// assumes requests arrive from internal cpu/dma logic on i_sys_clk (phase clock one)
// ready pins come from outside and are synchronised before use
`timescale 1ns/1ps
`include "zwsb_regs.svh"

// Functional notes
// - two buses each carry two strobes, two enables, two readies, pages, rw, address and data enables.
// - back-to-back reads keep the strobe low and read-write high.
// - each zero-wait write spends two clock cycles on the bus.
// - read-write stays low between writes while the strobe rises between them.
// - the strobe is high for an extra cycle while the address changes between writes.
// - a write is taken by the requester in one cycle when the interface is free.
// - read-write changes only while the strobe is high.
// - with the minimum range value, strobe 0 serves only the first 64K words.
// - software sets the page field to one page when one bank sits behind a strobe.
// - ready is active low and tied low it gives zero wait states.
// - the strobe range field lives in bits 24 to 28 of each bus config word.
module zwsb_bus_seq
  import zwsb_pkg::*;
#(
  parameter int ADDR_W = `ZWSB_ADDR_W
)
(
  // clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_reset_n,
  // bus configuration words (range field in bits 28:24)
  input  wire logic [31:0]       i_local_bus_config_reg,
  input  wire logic [31:0]       i_global_bus_config_reg,
  // local requester
  input  wire logic              i_local_valid,
  input  wire logic              i_local_write,
  input  wire logic [ADDR_W-1:0] i_local_addr,
  output logic                   o_local_accept,
  // global requester
  input  wire logic              i_global_valid,
  input  wire logic              i_global_write,
  input  wire logic [ADDR_W-1:0] i_global_addr,
  output logic                   o_global_accept,
  // ready pins, active low, asynchronous to the clock
  input  wire logic              i_local_ready_in_0_n,
  input  wire logic              i_local_ready_in_1_n,
  input  wire logic              i_global_ready_in_0_n,
  input  wire logic              i_global_ready_in_1_n,
  // local pins
  output logic                   o_local_bank_strobe_0_n,
  output logic                   o_local_bank_strobe_1_n,
  output logic                   o_local_read_write_0,
  output logic                   o_local_read_write_1,
  output logic                   o_local_page_flag_0_n,
  output logic                   o_local_page_flag_1_n,
  output logic                   o_local_address_drive_enable_n,
  output logic                   o_local_data_drive_enable_n,
  output logic                   o_local_control_enable_0_n,
  output logic                   o_local_control_enable_1_n,
  // global pins
  output logic                   o_global_bank_strobe_0_n,
  output logic                   o_global_bank_strobe_1_n,
  output logic                   o_global_read_write_0,
  output logic                   o_global_read_write_1,
  output logic                   o_global_page_flag_0_n,
  output logic                   o_global_page_flag_1_n,
  output logic                   o_global_address_drive_enable_n,
  output logic                   o_global_data_drive_enable_n,
  output logic                   o_global_control_enable_0_n,
  output logic                   o_global_control_enable_1_n
);

  // index 0..1 local strobes, 2..3 global strobes
  logic [3:0] rdy_meta_r;
  logic [3:0] rdy_sync_r;
  logic [3:0] sel;
  logic [3:0] valid;
  logic [3:0] accept;
  logic [3:0] busy;
  logic [3:0] strobe_n;
  logic [3:0] rw;
  logic [3:0] page_n;
  logic [4:0] local_range;
  logic [4:0] global_range;
  logic       local_sel0;
  logic       global_sel0;

  // two-flop synchronisers on the ready pins; the first stage feeds only the second
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      rdy_meta_r <= 4'hF;
      rdy_sync_r <= 4'hF;
    end else begin
      rdy_meta_r <= {i_global_ready_in_1_n, i_global_ready_in_0_n,
                     i_local_ready_in_1_n, i_local_ready_in_0_n};
      rdy_sync_r <= rdy_meta_r;
    end
  end

  // strobe 0 covers addresses below 2^(range+1); range 0x0F gives the first 64K words
  assign local_range  = i_local_bus_config_reg[`ZWSB_RANGE_MSB:`ZWSB_RANGE_LSB];
  assign global_range = i_global_bus_config_reg[`ZWSB_RANGE_MSB:`ZWSB_RANGE_LSB];
  // shift count widened to six bits so a range of 31 does not wrap to zero
  assign local_sel0   = ((i_local_addr >> ({1'b0, local_range} + 6'h01)) == '0);
  assign global_sel0  = ((i_global_addr >> ({1'b0, global_range} + 6'h01)) == '0);
  assign sel   = {!global_sel0, global_sel0, !local_sel0, local_sel0};
  assign valid = {{2{i_global_valid}} & sel[3:2], {2{i_local_valid}} & sel[1:0]};

  // four independent strobe sets, identical logic per set
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_set
      zwsb_req_if rq ();
      assign rq.valid   = valid[g];
      assign rq.write   = (g < 2) ? i_local_write : i_global_write;
      assign rq.ready_n = rdy_sync_r[g];
      assign accept[g]  = rq.accept;
      assign busy[g]    = rq.busy;
      zwsb_strobe_seq u_seq (
        .i_sys_clk    (i_sys_clk),
        .i_reset_n    (i_reset_n),
        .req          (rq),
        .o_strobe_n   (strobe_n[g]),
        .o_read_write (rw[g]),
        .o_page_n     (page_n[g])
      );
    end
  endgenerate

  // requester handshakes
  assign o_local_accept  = |accept[1:0];
  assign o_global_accept = |accept[3:2];

  // pin map for both buses; bus enables are held asserted, no external master
  assign o_local_bank_strobe_0_n         = strobe_n[0];
  assign o_local_bank_strobe_1_n         = strobe_n[1];
  assign o_local_read_write_0            = rw[0];
  assign o_local_read_write_1            = rw[1];
  assign o_local_page_flag_0_n           = page_n[0];
  assign o_local_page_flag_1_n           = page_n[1];
  assign o_local_address_drive_enable_n  = 1'b0;
  assign o_local_data_drive_enable_n     = 1'b0;
  assign o_local_control_enable_0_n      = 1'b0;
  assign o_local_control_enable_1_n      = 1'b0;
  assign o_global_bank_strobe_0_n        = strobe_n[2];
  assign o_global_bank_strobe_1_n        = strobe_n[3];
  assign o_global_read_write_0           = rw[2];
  assign o_global_read_write_1           = rw[3];
  assign o_global_page_flag_0_n          = page_n[2];
  assign o_global_page_flag_1_n          = page_n[3];
  assign o_global_address_drive_enable_n = 1'b0;
  assign o_global_data_drive_enable_n    = 1'b0;
  assign o_global_control_enable_0_n     = 1'b0;
  assign o_global_control_enable_1_n     = 1'b0;

endmodule

/* zwsb_regs.svh */
// timing counts, field positions and field values for the zero-wait bus sequencer
// assumes inclusion by the package and the design modules; definitions only
`ifndef ZWSB_REGS_SVH
`define ZWSB_REGS_SVH

`define ZWSB_CLK_MHZ          25
`define ZWSB_RANGE_LSB        24
`define ZWSB_RANGE_MSB        28
`define ZWSB_RANGE_MIN        5'h0F
`define ZWSB_PAGE_SINGLE      5'h0F
`define ZWSB_WRITE_CYCLES     2
`define ZWSB_ADDR_W           31

`endif

/* zwsb_pkg.sv */
// types shared by the zero-wait bus sequencer modules
// assumes zwsb_regs.svh is on the include path
`include "zwsb_regs.svh"

package zwsb_pkg;

  // per-strobe sequencer states
  typedef enum logic [1:0] {
    ZWSB_IDLE  = 2'b00,
    ZWSB_READ  = 2'b01,
    ZWSB_WR_A  = 2'b10,
    ZWSB_WR_B  = 2'b11
  } zwsb_state_e;

endpackage

/* zwsb_req_if.sv */
// request carrier from the bus top to one strobe sequencer
// assumes a single clock domain shared by both ends
`timescale 1ns/1ps

interface zwsb_req_if;
  logic valid;  // request for this strobe
  logic write;  // 1 write, 0 read
  logic ready_n;  // synchronised external ready
  logic accept;  // request taken this cycle
  logic busy;  // strobe set active or tail running

  modport top (output valid, output write, output ready_n, input accept, input busy);
  modport seq (input valid, input write, input ready_n, output accept, output busy);
endinterface

/* zwsb_strobe_seq.sv */
// one strobe set sequencer: strobe, read-write, page flag
// assumes requests come from logic on the same clock
`timescale 1ns/1ps

module zwsb_strobe_seq
  import zwsb_pkg::*;
(
  // clock and reset
  input  wire logic  i_sys_clk,
  input  wire logic  i_reset_n,
  // request port
  zwsb_req_if.seq    req,
  // pins
  output logic       o_strobe_n,
  output logic       o_read_write,
  output logic       o_page_n
);

  zwsb_state_e state_r;
  zwsb_state_e state_nxt;
  logic        wr_req;
  logic        rd_req;
  logic        rw_r;

  assign wr_req = req.valid && req.write;
  assign rd_req = req.valid && !req.write;

  // reads and writes are taken only while ready is low; a write is taken in one cycle
  // when the sequencer is idle or finishing, its second bus cycle runs behind
  assign req.accept = (rd_req && !req.ready_n && (state_r != ZWSB_WR_A) &&
                       (rw_r || state_r == ZWSB_IDLE || state_r == ZWSB_WR_B))
                    || (wr_req && (state_r == ZWSB_IDLE || state_r == ZWSB_WR_B)
                        && !rw_r == (state_r == ZWSB_WR_B) && !req.ready_n);
  assign req.busy   = (state_r != ZWSB_IDLE);

  // next state: a write takes WR_A (strobe low) then WR_B (strobe high)
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ZWSB_IDLE: state_nxt = req.accept ? (req.write ? ZWSB_WR_A : ZWSB_READ) : ZWSB_IDLE;
      ZWSB_READ: state_nxt = req.accept ? ZWSB_READ : ZWSB_IDLE;
      ZWSB_WR_A: state_nxt = ZWSB_WR_B;
      ZWSB_WR_B: state_nxt = req.accept ? (req.write ? ZWSB_WR_A : ZWSB_READ) : ZWSB_IDLE;
      default:   state_nxt = ZWSB_IDLE;
    endcase
  end

  // state and read-write registers, strobe is decoded from state_r; rw moves only in idle or WR_B
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      state_r <= ZWSB_IDLE;
      rw_r    <= 1'b1;
    end else begin
      state_r <= state_nxt;
      if (state_r == ZWSB_IDLE || state_r == ZWSB_WR_B)
        rw_r  <= !(req.accept && req.write);
    end
  end

  // strobe low in read or first write cycle; high in the write tail
  assign o_strobe_n   = !(state_r == ZWSB_READ || state_r == ZWSB_WR_A);
  assign o_read_write = rw_r;
  assign o_page_n     = 1'b1; // single page per strobe, no page switching

endmodule

/* zwsb_sram_model.sv */
// ready source standing in for the zero-wait rams of one bus
// assumes the bench drives i_slow on its clock edges
`timescale 1ns/1ps
module zwsb_sram_model (
  // stall control
  input  wire logic i_slow,
  // ready pins, active low
  output logic      o_ready_0_n,
  output logic      o_ready_1_n
);
  // fast parts tie ready low; a slow part holds it high
  assign o_ready_0_n = i_slow;
  assign o_ready_1_n = i_slow;
endmodule

/* zwsb_bus_seq_asserts.sv */
// checker for local strobe framing, decode and ready gating
// assumes binding to zwsb_bus_seq by port name
`timescale 1ns/1ps
module zwsb_bus_seq_chk
  import zwsb_pkg::*;
#(parameter int ADDR_W = 31)
(
  // clock, reset and requester
  input wire logic              i_sys_clk,
  input wire logic              i_reset_n,
  input wire logic [31:0]       i_local_bus_config_reg,
  input wire logic              i_local_valid,
  input wire logic              i_local_write,
  input wire logic [ADDR_W-1:0] i_local_addr,
  input wire logic              i_local_ready_in_0_n,
  // outputs watched
  input wire logic              o_local_accept,
  input wire logic              o_local_bank_strobe_0_n,
  input wire logic              o_local_bank_strobe_1_n,
  input wire logic              o_local_read_write_0
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  // request taken, and whether it decodes to strobe 0
  wire logic sel = (i_local_addr >> ({1'b0, i_local_bus_config_reg[28:24]} + 6'h01)) == '0;
  wire logic tk = o_local_accept && i_local_valid;
  rd_strobe_a: assert property (tk && sel && !i_local_write |=>
    !o_local_bank_strobe_0_n && o_local_read_write_0) else $error("read framing");
  wr_two_a: assert property (tk && sel && i_local_write |=>
    !o_local_bank_strobe_0_n && !o_local_read_write_0 ##1
    o_local_bank_strobe_0_n && !o_local_read_write_0) else $error("write cycles");
  wr_frame_a: assert property (!o_local_bank_strobe_0_n && !o_local_read_write_0 |=>
    o_local_bank_strobe_0_n) else $error("write strobe not lifted");
  rw_framed_a: assert property (!$stable(o_local_read_write_0) |->
    $past(o_local_bank_strobe_0_n)) else $error("rw moved under strobe");
  wr_refuse_a: assert property (tk && i_local_write |=> !o_local_accept)
    else $error("accept in first write cycle");
  range_sel_a: assert property ($fell(o_local_bank_strobe_1_n) |-> $past(tk && !sel))
    else $error("strobe 1 decode");
  rdy_gate_a: assert property (tk && sel |-> !$past(i_local_ready_in_0_n, 2))
    else $error("accept without ready");
  rst_idle_a: assert property (!$past(i_reset_n) |-> o_local_bank_strobe_0_n &&
    o_local_bank_strobe_1_n && o_local_read_write_0) else $error("not idle after reset");
  // main scenarios reached
  cover property (tk && !sel);
  cover property (tk && i_local_write ##2 tk && i_local_write);
  cover property (tk && !i_local_write ##1 tk);
endmodule
bind zwsb_bus_seq zwsb_bus_seq_chk #(.ADDR_W(ADDR_W)) u_zwsb_bus_seq_chk (.*);

/* tb.sv */
// bench for the bus sequencer: corner and random requests on both buses
// assumes design, ready model and checker are compiled first
`timescale 1ns/1ps
module tb;
  logic             i_sys_clk = 1'b0;
  logic             i_reset_n = 1'b0;
  logic [1:0][31:0] cfg = {2{32'h0F00_0000}};
  logic [1:0][30:0] adr = '0;
  logic [1:0]       vld = 2'h0;
  logic [1:0]       wr = 2'h0;
  logic [1:0]       slow = 2'h0;
  wire  [1:0]       acc;
  wire  [3:0]       rdy, stb, rw, pg, ce, en;
  int               n_mismatch = 0;
  int               tests_run = 0;
  logic             tl = 1'b0;
  int               ti = 0;
  // 40 ns clock
  always #20 i_sys_clk = ~i_sys_clk;
  for (genvar g = 0; g < 2; g++) begin : gm
    zwsb_sram_model u_zwsb_sram_model (.i_slow(slow[g]), .o_ready_0_n(rdy[2*g]),
      .o_ready_1_n(rdy[2*g+1]));
  end
  zwsb_bus_seq u_zwsb_bus_seq (.i_sys_clk, .i_reset_n, .i_local_bus_config_reg(cfg[0]),
    .i_global_bus_config_reg(cfg[1]), .i_local_valid(vld[0]), .i_local_write(wr[0]),
    .i_local_addr(adr[0]), .o_local_accept(acc[0]), .i_global_valid(vld[1]),
    .i_global_write(wr[1]), .i_global_addr(adr[1]), .o_global_accept(acc[1]),
    .i_local_ready_in_0_n(rdy[0]), .i_local_ready_in_1_n(rdy[1]),
    .i_global_ready_in_0_n(rdy[2]), .i_global_ready_in_1_n(rdy[3]),
    .o_local_bank_strobe_0_n(stb[0]), .o_local_bank_strobe_1_n(stb[1]),
    .o_global_bank_strobe_0_n(stb[2]), .o_global_bank_strobe_1_n(stb[3]),
    .o_local_read_write_0(rw[0]), .o_local_read_write_1(rw[1]),
    .o_global_read_write_0(rw[2]), .o_global_read_write_1(rw[3]),
    .o_local_page_flag_0_n(pg[0]), .o_local_page_flag_1_n(pg[1]),
    .o_global_page_flag_0_n(pg[2]), .o_global_page_flag_1_n(pg[3]),
    .o_local_address_drive_enable_n(en[0]), .o_local_data_drive_enable_n(en[1]),
    .o_global_address_drive_enable_n(en[2]), .o_global_data_drive_enable_n(en[3]),
    .o_local_control_enable_0_n(ce[0]), .o_local_control_enable_1_n(ce[1]),
    .o_global_control_enable_0_n(ce[2]), .o_global_control_enable_1_n(ce[3]));
  // strobe that the range field selects for a word address
  function automatic logic exp_sel(input logic [31:0] c, input logic [30:0] a);
    return (a >> ({1'b0, c[28:24]} + 6'h01)) != 31'h0;
  endfunction
  task automatic chk(input string nm, input logic e, input logic s);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %b seen %b", nm, e, s);
    end
  endtask
  task automatic results;
    if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // second write cycle: strobe lifted, read-write still low
  task automatic tail;
    if (tl) chk("tail_strobe", 1'b1, stb[ti]);
    if (tl) chk("tail_rw", 1'b0, rw[ti]);
    tl = 1'b0;
  endtask
  // request held until taken, then n strobe cycles followed; stall first flushes the syncs
  task automatic op(input int g, input logic w, input logic [30:0] a, input int n, input int st);
    int k;
    int i;
    k = 0;
    if (st > 0) begin
      slow[g] <= 1'b1;
      @(negedge i_sys_clk);
      tail();
      repeat (3) @(posedge i_sys_clk);
    end
    vld[g] <= 1'b1;
    wr[g] <= w;
    adr[g] <= a;
    @(negedge i_sys_clk);
    tail();
    while (acc[g] !== 1'b1) begin
      @(posedge i_sys_clk);
      k++;
      if (k == st) slow[g] <= 1'b0;
      if (k > 30) chk("accept_wait", 1'b1, 1'b0);
      if (k > 30) results();
      @(negedge i_sys_clk);
    end
    chk("ready_gate", 1'b1, st == 0 || k > st);
    i = 2 * g + exp_sel(cfg[g], a);
    for (int j = 1; j <= n; j++) begin
      @(posedge i_sys_clk);
      if (j == n) vld[g] <= 1'b0;
      @(negedge i_sys_clk);
      chk("strobe", 1'b0, stb[i]);
      chk("other_strobe", 1'b1, stb[i^1]);
      chk("rw", !w, rw[i]);
      if (j < n) chk("back_to_back", 1'b1, acc[g]);
    end
    @(posedge i_sys_clk);
    tl = w;
    ti = i;
  endtask
  initial begin
    logic w;
    int g;
    void'($urandom(32'h373E43CE));
    repeat (6) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    op(0, 1'b0, 31'h0000_0010, 3, 0);
    op(0, 1'b1, 31'h0000_0011, 1, 0);
    op(0, 1'b1, 31'h0000_FFFF, 1, 0);
    op(0, 1'b0, 31'h0001_0000, 2, 0);
    op(1, 1'b1, 31'h0000_0020, 1, 4);
    for (int t = 0; t < 80; t++) begin
      g = t % 2;
      w = 1'($urandom);
      if (t % 6 < 2) cfg[g] <= $urandom & 32'hE0FF_FFFF | {3'h0, 5'($urandom_range(20, 4)), 24'h0};
      op(g, w, 31'($urandom) >> $urandom_range(30, 8), w ? 1 : 1 + $urandom_range(2),
        $urandom_range(3) == 0 ? 3 : 0);
    end
    @(negedge i_sys_clk);
    tail();
    chk("pins", 1'b1, pg === 4'hF && en === 4'h0 && ce === 4'h0);
    results();
  end
endmodule
